// File: hw/lae_line_alarm_event_status.sv
`timescale 1ns/1ps
// Summary of operation
// - remote alarm condition flag follows received remote alarm, E1 only, both edges
// - distant multiframe alarm: TS16 frame 0 bit 6 set two multiframes running
// - link identification flag follows detected link signal, E1 only, both edges
// - receive clock loss flag after one channel time without transition, clears on resume
// - transmit clock loss flag likewise; drives shared pin high when selected
// - loop-up flag high while loop-up code matches, T1 only
// - loop-down flag high while loop-down code matches, T1 only
// - spare code flag high while spare code matches, T1 only
// - alarm mask bit set interrupts on rising and falling edges, clear masks
// - unframed-ones clear and yellow clear masks: 1 enables, 0 masks
// - receive align-frame event latched each received align frame, E1 only
// - transmit align-frame event latched each transmit align frame, E1 only
// - receive CRC-4 multiframe event latched on each boundary, E1 only
// - receive multiframe event latched on each receive multiframe boundary
// - transmit multiframe event latched on each transmit multiframe boundary
// - signaling all-zeros event when TS16 all zero over a multiframe, E1
// - signaling all-ones event when TS16 has under three zeros in 16 frames
// - customer alarm-indication event on detected pattern, T1 only
// - status and mask registers at their addresses, all but the live alarm status resetting to zero
// - event bits latch and hold until their status register is read
// - common control bit 0 selects shared pin: loss of sync or tx clock loss
module lae_line_alarm_event_status
    import lae_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // framer mode
    input wire logic i_e1_mode,
    // framer conditions, levels
    input wire logic i_remote_alarm,
    input wire logic i_link_ident_detect,
    input wire logic i_loop_up_match,
    input wire logic i_loop_down_match,
    input wire logic i_spare_match,
    input wire logic i_rx_loss_of_sync,
    // framer events, one-cycle pulses
    input wire logic i_sync_achieved,
    input wire logic i_unframed_ones_clear,
    input wire logic i_yellow_alarm_clear,
    input wire logic i_rx_align_frame,
    input wire logic i_rx_crc_multiframe,
    input wire logic i_rx_multiframe,
    input wire logic i_tx_align_frame,
    input wire logic i_tx_multiframe,
    input wire logic i_ais_customer_detect,
    // received time slot 16, one strobe per frame
    input wire logic i_ts16_valid,
    input wire logic [7:0] i_ts16_byte,
    input wire logic [3:0] i_rx_frame_num,
    // line clock pins
    input wire logic i_rx_line_clock_in,
    input wire logic i_tx_line_clock,
    // outputs
    output logic o_shared_status_pin,
    output logic o_int_n
);

    // bus decode
    wire logic [7:0] reg_index = i_avs_address[9:2];
    wire logic hit_event_status = (reg_index == LAE_IDX_EVENT_STATUS);
    wire logic hit_event_mask = (reg_index == LAE_IDX_EVENT_MASK);
    wire logic hit_alarm_status = (reg_index == LAE_IDX_ALARM_STATUS);
    wire logic hit_alarm_mask = (reg_index == LAE_IDX_ALARM_MASK);
    wire logic hit_frame_status = (reg_index == LAE_IDX_FRAME_STATUS);
    wire logic hit_frame_mask = (reg_index == LAE_IDX_FRAME_MASK);
    wire logic hit_common = (reg_index == LAE_IDX_COMMON_CONTROL_ONE);

    logic ack_q;
    // every access takes one wait state, then completes
    wire logic access = (i_avs_read | i_avs_write) & ~ack_q;
    wire logic rd_take = i_avs_read & ~ack_q;
    wire logic wr_take = i_avs_write & ~ack_q & i_avs_byteenable[0];
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ack_q <= 1'b0;
        else
            ack_q <= access;
    end

    // writable registers
    logic [7:0] event_mask_q;
    logic [7:0] alarm_mask_q;
    logic [7:0] frame_mask_q;
    logic [7:0] common_one_q;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            event_mask_q <= LAE_RESET_VALUE;
            alarm_mask_q <= LAE_RESET_VALUE;
            frame_mask_q <= LAE_RESET_VALUE;
            common_one_q <= LAE_RESET_VALUE;
        end
        else if (wr_take)
        begin
            if (hit_event_mask)
                event_mask_q <= i_avs_writedata[7:0] & LAE_EVENT_IMPL_MASK;
            if (hit_alarm_mask)
                alarm_mask_q <= i_avs_writedata[7:0];
            if (hit_frame_mask)
                frame_mask_q <= i_avs_writedata[7:0];
            if (hit_common)
                common_one_q <= i_avs_writedata[7:0];
        end
    end

    // line clock pins cross into the system clock domain
    logic [1:0] rx_clk_sync_q;
    logic [1:0] tx_clk_sync_q;
    logic rx_clk_prev_q;
    logic tx_clk_prev_q;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_clk_sync_q <= 2'b00;
            tx_clk_sync_q <= 2'b00;
            rx_clk_prev_q <= 1'b0;
            tx_clk_prev_q <= 1'b0;
        end
        else
        begin
            rx_clk_sync_q <= {rx_clk_sync_q[0], i_rx_line_clock_in};
            tx_clk_sync_q <= {tx_clk_sync_q[0], i_tx_line_clock};
            rx_clk_prev_q <= rx_clk_sync_q[1];
            tx_clk_prev_q <= tx_clk_sync_q[1];
        end
    end

    wire logic rx_clk_edge = rx_clk_sync_q[1] ^ rx_clk_prev_q;
    wire logic tx_clk_edge = tx_clk_sync_q[1] ^ tx_clk_prev_q;
    // the line clock is far slower than ours is fast only in the sense of edges seen;
    // a line clock above half our rate aliases and is not judged reliably
    wire logic [LAE_LOSS_CNT_W-1:0] loss_limit = i_e1_mode ?
        LAE_LOSS_CNT_W'(LAE_E1_CHANNEL_CYC) : LAE_LOSS_CNT_W'(LAE_T1_CHANNEL_CYC);

    logic [LAE_LOSS_CNT_W-1:0] rx_idle_q;
    logic [LAE_LOSS_CNT_W-1:0] tx_idle_q;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_idle_q <= '0;
            tx_idle_q <= '0;
        end
        else
        begin
            if (rx_clk_edge)
                rx_idle_q <= '0;
            else if (rx_idle_q < loss_limit)
                rx_idle_q <= rx_idle_q + LAE_LOSS_CNT_W'(1);
            if (tx_clk_edge)
                tx_idle_q <= '0;
            else if (tx_idle_q < loss_limit)
                tx_idle_q <= tx_idle_q + LAE_LOSS_CNT_W'(1);
        end
    end

    wire logic rx_clock_loss_flag = (rx_idle_q >= loss_limit);
    wire logic tx_clock_loss_flag = (tx_idle_q >= loss_limit);

    // time slot 16 monitors
    function automatic logic [3:0] zeros_in(input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < 8; k++)
            n = n + {3'b000, ~b[k]};
        return n;
    endfunction : zeros_in

    logic [1:0] dma_count_q;
    logic [7:0] ts16_or_q;
    logic [7:0] ts16_zeros_q;
    wire logic frame_first = (i_rx_frame_num == LAE_FRAME_FIRST);
    wire logic frame_last = (i_rx_frame_num == LAE_FRAME_LAST);
    wire logic [7:0] or_so_far = frame_first ? 8'h00 : ts16_or_q;
    wire logic [7:0] zeros_so_far = frame_first ? 8'h00 : ts16_zeros_q;
    wire logic [7:0] ts16_or_d = or_so_far | i_ts16_byte;
    wire logic [7:0] ts16_zeros_d = zeros_so_far + {4'h0, zeros_in(i_ts16_byte)};

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            dma_count_q <= 2'b00;
            ts16_or_q <= 8'h00;
            ts16_zeros_q <= 8'h00;
        end
        else if (i_ts16_valid)
        begin
            ts16_or_q <= ts16_or_d;
            ts16_zeros_q <= ts16_zeros_d;
            if (frame_first)
            begin
                if (!i_ts16_byte[LAE_TS16_DMA_BIT])
                    dma_count_q <= 2'b00;
                else if (dma_count_q != LAE_DMA_REPEATS)
                    dma_count_q <= dma_count_q + 2'b01;
            end
        end
    end

    // detection stays on in common-channel signaling as well
    wire logic distant_mf_alarm_flag = i_e1_mode & (dma_count_q == LAE_DMA_REPEATS);
    wire logic mf_closing = i_ts16_valid & frame_last & i_e1_mode;
    wire logic signaling_all_zero_hit = mf_closing & (ts16_or_d == 8'h00);
    wire logic signaling_all_one_hit = mf_closing & (ts16_zeros_d < LAE_ALL_ONES_ZERO_LIMIT);

    // alarm conditions, live
    wire logic [7:0] alarm_live = {
        ~i_e1_mode & i_spare_match,
        ~i_e1_mode & i_loop_down_match,
        ~i_e1_mode & i_loop_up_match,
        tx_clock_loss_flag,
        rx_clock_loss_flag,
        i_e1_mode & i_link_ident_detect,
        distant_mf_alarm_flag,
        i_e1_mode & i_remote_alarm
    };

    logic [7:0] alarm_prev_q;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            alarm_prev_q <= LAE_RESET_VALUE;
        else
            alarm_prev_q <= alarm_live;
    end

    // any change in either direction is an edge worth reporting
    wire logic [7:0] alarm_edge = alarm_live ^ alarm_prev_q;
    wire logic [7:0] alarm_irq_set = alarm_edge & alarm_mask_q;

    // frame events
    wire logic [7:0] frame_set = {
        ~i_e1_mode & i_ais_customer_detect,
        signaling_all_one_hit,
        signaling_all_zero_hit,
        i_tx_multiframe,
        i_e1_mode & i_tx_align_frame,
        i_rx_multiframe,
        i_e1_mode & i_rx_crc_multiframe,
        i_e1_mode & i_rx_align_frame
    };

    logic [7:0] event_set;
    always_comb
    begin
        event_set = 8'h00;
        event_set[LAE_BIT_SYNC_ACHIEVED] = i_sync_achieved;
        event_set[LAE_BIT_UNFRAMED_ONES_CLEAR] = i_unframed_ones_clear;
        event_set[LAE_BIT_YELLOW_CLEAR] = i_yellow_alarm_clear;
    end

    wire logic clr_event = rd_take & hit_event_status;
    wire logic clr_alarm = rd_take & hit_alarm_status;
    wire logic clr_frame = rd_take & hit_frame_status;
    logic [7:0] event_flags;
    logic [7:0] alarm_irq_flags;
    logic [7:0] frame_flags;

    lae_sticky_bits #(.WIDTH(8)) u_event_flags (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_set(event_set),
        .i_clear(clr_event),
        .o_flags(event_flags)
    );

    lae_sticky_bits #(.WIDTH(8)) u_alarm_irq (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_set(alarm_irq_set),
        .i_clear(clr_alarm),
        .o_flags(alarm_irq_flags)
    );

    lae_sticky_bits #(.WIDTH(8)) u_frame_flags (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_set(frame_set),
        .i_clear(clr_frame),
        .o_flags(frame_flags)
    );

    // read data mux
    wire logic [7:0] read_byte =
        hit_event_status ? event_flags :
        hit_event_mask ? event_mask_q :
        hit_alarm_status ? alarm_live :
        hit_alarm_mask ? alarm_mask_q :
        hit_frame_status ? frame_flags :
        hit_frame_mask ? frame_mask_q :
        hit_common ? common_one_q : 8'h00;
    wire logic mapped = hit_event_status | hit_event_mask | hit_alarm_status | hit_alarm_mask |
        hit_frame_status | hit_frame_mask | hit_common;

    logic [31:0] readdata_q;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            readdata_q <= LAE_UNMAPPED_READ;
        else if (rd_take)
            readdata_q <= mapped ? {24'h000000, read_byte} : LAE_UNMAPPED_READ;
    end

    assign o_avs_readdata = readdata_q;

    // interrupt and shared pin outputs
    wire logic irq_any = |(event_flags & event_mask_q) |
        |alarm_irq_flags |
        |(frame_flags & frame_mask_q);
    wire logic shared_pin_d = common_one_q[LAE_BIT_SHARED_PIN_SELECT] ?
        tx_clock_loss_flag : i_rx_loss_of_sync;

    logic int_n_q;
    logic shared_pin_q;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            int_n_q <= 1'b1;
            shared_pin_q <= 1'b0;
        end
        else
        begin
            int_n_q <= ~irq_any;
            shared_pin_q <= shared_pin_d;
        end
    end

    assign o_int_n = int_n_q;
    assign o_shared_status_pin = shared_pin_q;

endmodule : lae_line_alarm_event_status

// File: hw/lae_pkg.sv
package lae_pkg;

    // register indexes; byte address on the bus is four times the index
    localparam logic [7:0] LAE_IDX_EVENT_STATUS = 8'h18;
    localparam logic [7:0] LAE_IDX_EVENT_MASK = 8'h19;
    localparam logic [7:0] LAE_IDX_ALARM_STATUS = 8'h1a;
    localparam logic [7:0] LAE_IDX_ALARM_MASK = 8'h1b;
    localparam logic [7:0] LAE_IDX_FRAME_STATUS = 8'h1c;
    localparam logic [7:0] LAE_IDX_FRAME_MASK = 8'h1d;
    localparam logic [7:0] LAE_IDX_COMMON_CONTROL_ONE = 8'h70;

    localparam logic [7:0] LAE_RESET_VALUE = 8'h00;
    localparam logic [31:0] LAE_UNMAPPED_READ = 32'h0000_0000;

    // second status register: only the event bits kept by this block
    localparam int LAE_BIT_SYNC_ACHIEVED = 4;
    localparam int LAE_BIT_UNFRAMED_ONES_CLEAR = 6;
    localparam int LAE_BIT_YELLOW_CLEAR = 7;
    localparam logic [7:0] LAE_EVENT_IMPL_MASK = 8'hd0;

    // common control one
    localparam int LAE_BIT_SHARED_PIN_SELECT = 0;

    // time slot 16 checks
    localparam int LAE_TS16_DMA_BIT = 6;
    localparam logic [3:0] LAE_FRAME_FIRST = 4'h0;
    localparam logic [3:0] LAE_FRAME_LAST = 4'hf;
    localparam logic [1:0] LAE_DMA_REPEATS = 2'h2;
    localparam logic [7:0] LAE_ALL_ONES_ZERO_LIMIT = 8'h03;

    // clock loss: one channel time, rounded up to whole system clocks
    localparam int LAE_CLK_PERIOD_NS = 50;
    localparam int LAE_E1_CHANNEL_NS = 3906;
    localparam int LAE_T1_CHANNEL_NS = 5181;
    localparam int LAE_E1_CHANNEL_CYC = (LAE_E1_CHANNEL_NS + LAE_CLK_PERIOD_NS - 1) / LAE_CLK_PERIOD_NS;
    localparam int LAE_T1_CHANNEL_CYC = (LAE_T1_CHANNEL_NS + LAE_CLK_PERIOD_NS - 1) / LAE_CLK_PERIOD_NS;
    localparam int LAE_LOSS_CNT_W = 8;

endpackage : lae_pkg

// File: hw/lae_sticky_bits.sv
`timescale 1ns/1ps
// sticky flags: a set in the same cycle as the clear wins
module lae_sticky_bits #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // control
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_clear,
    // state
    output logic [WIDTH-1:0] o_flags
);
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    assign flags_d = i_set | (i_clear ? '0 : flags_q);
    assign o_flags = flags_q;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end
endmodule : lae_sticky_bits

// File: test/lae_line_alarm_event_status_sva.sv
`timescale 1ns/1ps
module lae_line_alarm_event_status_sva
    import lae_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // bus
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // framer side
    input wire logic i_e1_mode,
    input wire logic i_remote_alarm,
    input wire logic i_rx_loss_of_sync,
    input wire logic i_rx_multiframe,
    input wire logic i_tx_line_clock,
    input wire logic o_shared_status_pin,
    input wire logic o_int_n
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic sel_q;
    logic tx_prev_q;
    logic [7:0] amask_q;
    logic [7:0] fmask_q;
    logic [7:0] still_q;
    wire logic [7:0] idx_w = i_avs_address[9:2];
    wire logic wdone_w = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    wire logic mapped_w = (idx_w >= LAE_IDX_EVENT_STATUS && idx_w <= LAE_IDX_FRAME_MASK) ||
        idx_w == LAE_IDX_COMMON_CONTROL_ONE;
    // shadows follow completed writes, one edge behind the design's own copy
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            sel_q <= 1'b0;
            amask_q <= 8'h00;
            fmask_q <= 8'h00;
            still_q <= 8'h00;
            tx_prev_q <= 1'b0;
        end
        else
        begin
            if (wdone_w && idx_w == LAE_IDX_COMMON_CONTROL_ONE) sel_q <= i_avs_writedata[0];
            if (wdone_w && idx_w == LAE_IDX_ALARM_MASK) amask_q <= i_avs_writedata[7:0];
            if (wdone_w && idx_w == LAE_IDX_FRAME_MASK) fmask_q <= i_avs_writedata[7:0];
            tx_prev_q <= i_tx_line_clock;
            still_q <= (i_tx_line_clock != tx_prev_q) ? 8'h00 : (still_q == 8'hff ? still_q : still_q + 8'h01);
        end
    end
    sequence s_req_start;
        (i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write);
    endsequence
    sequence s_req_done;
        (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    endsequence
    a_wait_first: assert property (s_req_start |-> o_avs_waitrequest)
        else $error("request completed without a wait state");
    a_wait_one: assert property (s_req_start |=> s_req_done)
        else $error("request not completed after one wait state");
    a_read_upper_zero: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest && !mapped_w |->
        o_avs_readdata == LAE_UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_pin_sync_loss: assert property (!sel_q && !$past(sel_q) |->
        o_shared_status_pin == $past(i_rx_loss_of_sync))
        else $error("shared pin does not follow loss of sync");
    a_pin_tx_loss: assert property (sel_q && $past(sel_q) && still_q > 8'h78 |-> o_shared_status_pin)
        else $error("shared pin low with transmit clock lost");
    a_pin_tx_ok: assert property (sel_q && $past(sel_q) && still_q inside {[8'h08:8'h3c]} |->
        !o_shared_status_pin)
        else $error("shared pin high with transmit clock present");
    a_alarm_int: assert property ($changed(i_remote_alarm) && i_e1_mode &&
        $past(i_e1_mode) && amask_q[0] |-> ##[1:5] !o_int_n)
        else $error("no interrupt on enabled alarm change");
    a_event_int: assert property (i_rx_multiframe && fmask_q[2] |-> ##[1:5] !o_int_n)
        else $error("no interrupt on enabled multiframe event");
endmodule : lae_line_alarm_event_status_sva

bind lae_line_alarm_event_status lae_line_alarm_event_status_sva i_sva (.*);

// File: test/lae_host_model.sv
`timescale 1ns/1ps
module lae_host_model (
    // clock
    input wire logic i_clk_sys,
    // avalon-mm master
    output logic [9:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable,
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest
);
    initial
    begin
        o_address = 10'h000;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0;
        o_byteenable = 4'hf;
    end
    // request held until waitrequest is sampled low; released lines are scrambled
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge i_clk_sys);
        o_address <= {idx, 2'b00};
        o_read <= !wr;
        o_write <= wr;
        o_writedata <= {24'h0, wd};
        do
            @(posedge i_clk_sys);
        while (i_waitrequest !== 1'b0);
        rd = i_readdata[7:0];
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_address <= ~o_address;
        o_writedata <= ~o_writedata;
    endtask : xfer
endmodule : lae_host_model

// File: test/lae_line_alarm_event_status_tb.sv
`timescale 1ns/1ps
module lae_line_alarm_event_status_tb;
    import lae_pkg::*;
    logic i_clk_sys, i_rst, i_e1_mode, i_rx_loss_of_sync, i_ts16_valid, i_rx_line_clock_in, i_tx_line_clock;
    logic [9:0] i_avs_address;
    logic i_avs_read, i_avs_write, o_avs_waitrequest, o_shared_status_pin, o_int_n, rx_run, tx_run, act;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [3:0] i_avs_byteenable, i_rx_frame_num;
    logic [7:0] cond, i_ts16_byte, rdv, d, exp_v;
    logic [8:0] pul;
    int fail_count, total_checks, zeros, dma_run;
    bit allz;
    logic [7:0] q[$];
    int cb[5] = '{0, 2, 5, 6, 7};
    logic [7:0] midx[4] = '{8'h19, 8'h1b, 8'h1d, 8'h70};
    logic [7:0] mimp[4] = '{8'hd0, 8'hff, 8'hff, 8'hff};
    logic [7:0] pbit[9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h80, 8'h10, 8'h40, 8'h80};
    int pmode[9] = '{1, 1, 2, 1, 2, 0, 2, 2, 2};
    logic [7:0] b0t[5] = '{8'h00, 8'hff, 8'hff, 8'hbf, 8'h00};
    wire logic i_remote_alarm = cond[0];
    wire logic i_link_ident_detect = cond[2];
    wire logic i_loop_up_match = cond[5];
    wire logic i_loop_down_match = cond[6];
    wire logic i_spare_match = cond[7];
    wire logic i_rx_align_frame = pul[0];
    wire logic i_rx_crc_multiframe = pul[1];
    wire logic i_rx_multiframe = pul[2];
    wire logic i_tx_align_frame = pul[3];
    wire logic i_tx_multiframe = pul[4];
    wire logic i_ais_customer_detect = pul[5];
    wire logic i_sync_achieved = pul[6];
    wire logic i_unframed_ones_clear = pul[7];
    wire logic i_yellow_alarm_clear = pul[8];
    lae_line_alarm_event_status i_dut (.*);
    lae_host_model i_host (.i_clk_sys(i_clk_sys), .o_address(i_avs_address), .o_read(i_avs_read),
        .o_write(i_avs_write), .o_writedata(i_avs_writedata), .o_byteenable(i_avs_byteenable),
        .i_readdata(o_avs_readdata), .i_waitrequest(o_avs_waitrequest));
    initial
    begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    // line clocks toggle each cycle while running; loss of sync is random noise
    always @(posedge i_clk_sys)
    begin
        if (rx_run) i_rx_line_clock_in <= ~i_rx_line_clock_in;
        if (tx_run) i_tx_line_clock <= ~i_tx_line_clock;
        if (!i_rst) i_rx_loss_of_sync <= 1'($urandom);
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string what);
        i_host.xfer(1'b0, idx, 8'h00, rdv);
        chk(what, e, rdv);
    endtask : rd
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        i_host.xfer(1'b1, idx, v, rdv);
    endtask : wr
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (40000) @(posedge i_clk_sys);
        fail_count++;
        end_sim();
    end
    initial
    begin
        {i_rst, rx_run, tx_run, i_e1_mode} = 4'hf;
        {i_rx_loss_of_sync, i_ts16_valid, i_rx_line_clock_in, i_tx_line_clock} = 4'h0;
        {cond, pul, i_ts16_byte, i_rx_frame_num} = 29'h0;
        void'($urandom(32'hc792));
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        for (int k = 24; k < 30; k++) rd(8'(k), 8'h00, "reset value");
        wr(8'hff, 8'hff);
        rd(8'hff, 8'h00, "unmapped");
        foreach (midx[k])
        begin
            d = 8'($urandom);
            wr(midx[k], d);
            rd(midx[k], d & mimp[k], "mask readback");
        end
        wr(LAE_IDX_ALARM_MASK, 8'hff);
        for (int m = 1; m >= 0; m--)
        begin
            i_e1_mode <= m[0];
            rd(LAE_IDX_ALARM_STATUS, 8'h00, "alarm idle");
            foreach (cb[k])
            begin
                act = m[0] ? (cb[k] < 3) : (cb[k] > 4);
                exp_v = act ? 8'(1 << cb[k]) : 8'h00;
                cond[cb[k]] <= 1'b1;
                repeat (8) @(posedge i_clk_sys);
                chk("int on rise", {7'h0, !act}, {7'h0, o_int_n});
                rd(LAE_IDX_ALARM_STATUS, exp_v, "alarm status");
                // the clearing read drops the pending bit one edge before the pin follows
                @(posedge i_clk_sys);
                chk("int after read", 8'h01, {7'h0, o_int_n});
                cond[cb[k]] <= 1'b0;
                repeat (8) @(posedge i_clk_sys);
                chk("int on fall", {7'h0, !act}, {7'h0, o_int_n});
                rd(LAE_IDX_ALARM_STATUS, 8'h00, "alarm cleared");
            end
        end
        wr(LAE_IDX_ALARM_MASK, 8'h00);
        cond[5] <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        chk("masked change", 8'h01, {7'h0, o_int_n});
        cond[5] <= 1'b0;
        wr(LAE_IDX_FRAME_MASK, 8'hff);
        wr(LAE_IDX_EVENT_MASK, 8'hd0);
        rd(LAE_IDX_ALARM_STATUS, 8'h00, "alarm quiet");
        for (int m = 1; m >= 0; m--)
        begin
            i_e1_mode <= m[0];
            foreach (pbit[k])
            begin
                act = pmode[k] == 2 || pmode[k] == m;
                exp_v = act ? pbit[k] : 8'h00;
                pul[k] <= 1'b1;
                @(posedge i_clk_sys);
                pul[k] <= 1'b0;
                repeat (4) @(posedge i_clk_sys);
                chk("event int", {7'h0, !act}, {7'h0, o_int_n});
                rd(k < 6 ? LAE_IDX_FRAME_STATUS : LAE_IDX_EVENT_STATUS, exp_v, "event latch");
                rd(k < 6 ? LAE_IDX_FRAME_STATUS : LAE_IDX_EVENT_STATUS, 8'h00, "read clear");
                chk("event int clear", 8'h01, {7'h0, o_int_n});
            end
        end
        wr(LAE_IDX_EVENT_MASK, 8'h00);
        pul[6] <= 1'b1;
        @(posedge i_clk_sys);
        pul[6] <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        chk("masked event int", 8'h01, {7'h0, o_int_n});
        rd(LAE_IDX_EVENT_STATUS, pbit[6], "masked event latch");
        i_e1_mode <= 1'b1;
        dma_run = 0;
        foreach (b0t[j])
        begin
            d = (j == 3) ? 8'($urandom) : b0t[j];
            for (int f = 0; f < 16; f++)
            begin
                i_ts16_valid <= 1'b1;
                i_ts16_byte <= (f == 0) ? b0t[j] : d;
                i_rx_frame_num <= 4'(f);
                q.push_back((f == 0) ? b0t[j] : d);
                @(posedge i_clk_sys);
                i_ts16_valid <= 1'b0;
                @(posedge i_clk_sys);
            end
            zeros = 0;
            allz = 1'b1;
            foreach (q[i]) zeros += $countones(~q[i]);
            foreach (q[i]) allz &= (q[i] == 8'h00);
            q.delete();
            dma_run = b0t[j][LAE_TS16_DMA_BIT] ? dma_run + 1 : 0;
            repeat (3) @(posedge i_clk_sys);
            rd(LAE_IDX_FRAME_STATUS, {1'b0, zeros < 3, allz, 5'h0}, "ts16 events");
            rd(LAE_IDX_ALARM_STATUS, {6'h0, dma_run >= 2, 1'b0}, "distant alarm");
        end
        wr(LAE_IDX_COMMON_CONTROL_ONE, 8'h01);
        rx_run <= 1'b0;
        repeat (60) @(posedge i_clk_sys);
        rd(LAE_IDX_ALARM_STATUS, 8'h00, "rx clock short gap");
        repeat (60) @(posedge i_clk_sys);
        rd(LAE_IDX_ALARM_STATUS, 8'h08, "rx clock lost");
        rx_run <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        rd(LAE_IDX_ALARM_STATUS, 8'h00, "rx clock back");
        tx_run <= 1'b0;
        repeat (130) @(posedge i_clk_sys);
        chk("pin on tx loss", 8'h01, {7'h0, o_shared_status_pin});
        rd(LAE_IDX_ALARM_STATUS, 8'h10, "tx clock lost");
        tx_run <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        chk("pin tx back", 8'h00, {7'h0, o_shared_status_pin});
        wr(LAE_IDX_COMMON_CONTROL_ONE, 8'h00);
        repeat (40) @(posedge i_clk_sys);
        end_sim();
    end
endmodule : lae_line_alarm_event_status_tb
